/* hdl/spihp_pkg.sv */
// Summary of operation
// R01: Bit order 0 shifts MSB first, 1 shifts LSB first.
// R02: Host with select active: select low drops host mode, sets flag.
// R03: Clock double halves the host serial clock period.
// R04: Divider codes 0..3 give host clock divided by 4, 16, 64, 128.
// R05: Unit works only while the enable bit is one.
// R06: Buffered mode: two receive buffers, one transmit buffer, split flags.
// R07: Buffered, no receive wait: first byte out is a dummy.
// R08: Buffered with receive wait: first idle write loads the shift register.
// R09: Select ignore keeps host mode regardless of the select line.
// R10: Mode codes pick leading edge polarity and sample or setup edge.
// R11: Serial clock idles at the level opposite its leading edge.
// R12: Buffered mode enables gate their flags; unbuffered they read zero.
// R13: Unbuffered single enable gates the combined done flag.
// R14: Buffered receive flag follows unread data; write one clears.
// R15: Unbuffered done flag sets per byte and on select trigger.
// R16: Done flag clears on vector ack or flag read then data access.
// R17: Buffered transfer flag sets when shifter and buffer empty.
// R18: Unbuffered write while shifting sets the collision flag.
// R19: Empty flag high when transmit buffer empty; zero after reset.
// R20: Data write clears empty flag; software must refill or mask.
// R21: Buffered data read returns second buffer, first moves up.
// R22: Overflow sets on third byte with both buffers full.
// R23: Buffered select trigger flag sets on forced host exit.
// R24: Peripheral select high aborts the byte in progress.
// R25: Host clock has even duty and all logic shares one clock.
// R26: Interrupt output is high while any enabled flag is set.
package spihp_pkg;
   localparam logic [5:0] IDX_CTRL_A = 6'h00;
   localparam logic [5:0] IDX_CTRL_B = 6'h01;
   localparam logic [5:0] IDX_INTEN  = 6'h02;
   localparam logic [5:0] IDX_FLAGS  = 6'h03;
   localparam logic [5:0] IDX_DATA   = 6'h04;
   localparam logic [7:0] CTRL_A_RST = 8'h00;
   localparam logic [7:0] CTRL_B_RST = 8'h00;
   localparam logic [7:0] INTEN_RST  = 8'h00;
   localparam logic [7:0] DATA_RST   = 8'h00;
   localparam logic [7:0] CTRL_A_MSK = 8'h77;
   localparam logic [7:0] CTRL_B_MSK = 8'hc7;
   localparam logic [7:0] INTEN_MSK  = 8'hf1;
   localparam logic [6:0] HALF_DIV4   = 7'h02;
   localparam logic [6:0] HALF_DIV16  = 7'h08;
   localparam logic [6:0] HALF_DIV64  = 7'h20;
   localparam logic [6:0] HALF_DIV128 = 7'h40;
   localparam logic [3:0] LAST_EDGE  = 4'hf;
   localparam logic [3:0] PIN_RST    = 4'h8;
   typedef struct packed {
      logic       rsv7;
      logic       bit_order_sel;
      logic       host_mode;
      logic       sck_double;
      logic       rsv3;
      logic [1:0] sck_divider;
      logic       enable;
   } spihp_ctrl_a_s;
   typedef struct packed {
      logic       buffered_mode_en;
      logic       wait_for_receive;
      logic [2:0] rsv;
      logic       select_ignore;
      logic [1:0] mode;
   } spihp_ctrl_b_s;
endpackage

/* hdl/spihp_top.sv */
module spihp_top (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Interrupt
   input  wire logic        vector_ack,
   output logic             irq,
   // Serial pins
   input  wire logic        sck_in,
   output logic             sck_out,
   output logic             sck_oe_n,
   input  wire logic        mosi_in,
   output logic             mosi_out,
   output logic             mosi_oe_n,
   input  wire logic        miso_in,
   output logic             miso_out,
   output logic             miso_oe_n,
   input  wire logic        ss_n_in
);
   spihp_pkg::spihp_ctrl_a_s ctrl_a_reg;
   spihp_pkg::spihp_ctrl_b_s ctrl_b_reg;
   logic [7:0] inten_reg, sh_reg, txbuf_reg, rxd_reg, rx1_reg, rx2_reg;
   logic [7:0] rx1_next, rx2_next, rx_byte, flag_view, rd_val, wdat;
   logic [3:0] pin_s1_reg, pin_s2_reg, edge_cnt_reg;
   logic [6:0] div_cnt_reg, half, gap_reg;
   logic [5:0] wr_idx_reg;
   logic       wr_pend_reg, busy_reg, out_bit_reg, sck_d_reg, sck_reg;
   logic       sck_oe_n_reg, mosi_oe_n_reg, miso_oe_n_reg, irq_reg;
   logic       if_reg, write_collision_flag_reg, rxc_reg, txc_reg, dre_reg, select_trig_flag_reg;
   logic       ovf_reg, arm_if_reg, arm_wc_reg, txfull_reg;
   logic       rx1v_reg, rx2v_reg, rx1v_next, rx2v_next, ovf_set;
   logic       ss_n, sck_s, in_bit, en, host, bufm, cpha, cpol;
   logic       ap, rd_now, data_rd, data_wr, flags_rd, flags_wr, ctla_wr;
   logic       sel_trig, tick, pedge, edge_ev, lead, sample, setup, done;
   logic       busy_any, direct, auto_start, start, irq_src;

   // Pins pass two flops before any logic sees them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1_reg <= spihp_pkg::PIN_RST;
         pin_s2_reg <= spihp_pkg::PIN_RST;
      end else begin
         pin_s1_reg <= {ss_n_in, sck_in, mosi_in, miso_in};
         pin_s2_reg <= pin_s1_reg;
      end
   end
   assign ss_n  = pin_s2_reg[3];
   assign sck_s = pin_s2_reg[2];

   // Decoded configuration
   assign en   = ctrl_a_reg.enable;
   assign host = ctrl_a_reg.host_mode;
   assign bufm = ctrl_b_reg.buffered_mode_en;
   assign cpha = ctrl_b_reg.mode[0];
   assign cpol = ctrl_b_reg.mode[1];
   // Pin latency: host receive needs half periods of three cycles or more
   assign in_bit = host ? pin_s2_reg[0] : pin_s2_reg[1];

   // Bus decode: reads answer in the address phase, writes land next
   assign ap = hsel & htrans[1] & hready;
   assign rd_now = ap & ~hwrite & (haddr[1:0] == 2'h0);
   assign data_rd = rd_now & (haddr[7:2] == spihp_pkg::IDX_DATA);
   assign flags_rd = rd_now & (haddr[7:2] == spihp_pkg::IDX_FLAGS);
   assign wdat = hwdata[7:0];
   assign data_wr = wr_pend_reg & (wr_idx_reg == spihp_pkg::IDX_DATA);
   assign flags_wr = wr_pend_reg & (wr_idx_reg == spihp_pkg::IDX_FLAGS);
   assign ctla_wr = wr_pend_reg & (wr_idx_reg == spihp_pkg::IDX_CTRL_A);

   // Select low in host mode forces peripheral mode
   assign sel_trig = en & host & ~ctrl_b_reg.select_ignore & ~ss_n; // R02 R09

   // Half period of the host clock
   always_comb begin
      unique case (ctrl_a_reg.sck_divider) // R04
         2'h0: half = spihp_pkg::HALF_DIV4;
         2'h1: half = spihp_pkg::HALF_DIV16;
         2'h2: half = spihp_pkg::HALF_DIV64;
         2'h3: half = spihp_pkg::HALF_DIV128;
      endcase
      if (ctrl_a_reg.sck_double) begin
         half = half >> 1; // R03
      end
   end

   // Edge events; equal half periods give an even duty cycle
   assign tick = busy_reg & host & (div_cnt_reg == half - 7'h01); // R25
   assign pedge = en & ~host & ~ss_n & (sck_s != sck_d_reg);
   assign edge_ev = host ? tick : pedge;
   assign lead = host ? ~edge_cnt_reg[0] : (sck_s != cpol);
   assign sample = edge_ev & (lead ^ cpha); // R10
   assign setup = edge_ev & ~(lead ^ cpha); // R10
   assign done = edge_ev & (edge_cnt_reg == spihp_pkg::LAST_EDGE);
   assign busy_any = host ? busy_reg : (edge_cnt_reg != 4'h0);
   assign rx_byte = ~sample ? sh_reg :
                    ctrl_a_reg.bit_order_sel ? {in_bit, sh_reg[7:1]} :
                    {sh_reg[6:0], in_bit}; // R01

   // Transmit path choices
   assign direct = bufm & ctrl_b_reg.wait_for_receive & en & ss_n &
                   ~busy_any & ~txfull_reg; // R08
   assign auto_start = host & bufm & en & ~busy_reg & txfull_reg; // R07
   assign start = en & host & ~busy_reg & ~sel_trig &
                  (auto_start | (data_wr & (direct | ~bufm)));

   // Control registers; select trigger clears host mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_a_reg <= spihp_pkg::CTRL_A_RST;
         ctrl_b_reg <= spihp_pkg::CTRL_B_RST;
         inten_reg  <= spihp_pkg::INTEN_RST;
      end else begin
         if (ctla_wr) begin
            ctrl_a_reg <= wdat & spihp_pkg::CTRL_A_MSK;
         end else if (sel_trig) begin
            ctrl_a_reg.host_mode <= 1'b0; // R02
         end
         if (wr_pend_reg && wr_idx_reg == spihp_pkg::IDX_CTRL_B) begin
            ctrl_b_reg <= wdat & spihp_pkg::CTRL_B_MSK;
         end
         if (wr_pend_reg && wr_idx_reg == spihp_pkg::IDX_INTEN) begin
            inten_reg <= wdat & spihp_pkg::INTEN_MSK;
         end
      end
   end

   // Host clock generator and bit counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_reg     <= 1'b0;
         edge_cnt_reg <= 4'h0;
         div_cnt_reg  <= 7'h00;
         sck_reg      <= 1'b0;
         sck_d_reg    <= 1'b0;
      end else begin
         sck_d_reg <= sck_s;
         if (!en || sel_trig) begin
            busy_reg     <= 1'b0; // R05
            edge_cnt_reg <= 4'h0;
            div_cnt_reg  <= 7'h00;
            sck_reg      <= cpol;
         end else if (!host && ss_n) begin
            edge_cnt_reg <= 4'h0; // R24
            sck_reg      <= cpol;
         end else if (start) begin
            busy_reg     <= 1'b1;
            edge_cnt_reg <= 4'h0;
            div_cnt_reg  <= 7'h00;
         end else begin
            if (edge_ev) begin
               edge_cnt_reg <= edge_cnt_reg + 4'h1;
            end
            if (tick) begin
               div_cnt_reg <= 7'h00;
               sck_reg     <= ~sck_reg;
            end else if (busy_reg) begin
               div_cnt_reg <= div_cnt_reg + 7'h01;
            end else begin
               sck_reg <= cpol; // R11
            end
            if (done && host && !(bufm && txfull_reg)) begin
               busy_reg <= 1'b0;
            end
         end
      end
   end

   // Shift register, transmit buffer and output bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sh_reg      <= spihp_pkg::DATA_RST;
         txbuf_reg   <= spihp_pkg::DATA_RST;
         txfull_reg  <= 1'b0;
         out_bit_reg <= 1'b0;
      end else begin
         if (done) begin
            if (bufm && txfull_reg) begin
               sh_reg      <= txbuf_reg; // R06
               txfull_reg  <= 1'b0;
               out_bit_reg <= ctrl_a_reg.bit_order_sel ?
                              txbuf_reg[0] : txbuf_reg[7];
            end else begin
               sh_reg <= rx_byte; // Dummy is the last byte received
            end
         end else if (!host && ss_n && edge_cnt_reg != 4'h0) begin
            sh_reg <= sh_reg; // R24
         end else if (sample) begin
            sh_reg <= rx_byte;
         end else if (setup) begin
            out_bit_reg <= ctrl_a_reg.bit_order_sel ?
                           sh_reg[0] : sh_reg[7]; // R01
         end
         if (data_wr && en && ((!bufm && !busy_any) || direct)) begin
            sh_reg      <= wdat; // R08
            out_bit_reg <= ctrl_a_reg.bit_order_sel ? wdat[0] : wdat[7];
         end else if (data_wr && bufm && !direct && !txfull_reg) begin
            txbuf_reg  <= wdat; // R07
            txfull_reg <= 1'b1;
         end
      end
   end

   // Receive buffers: a read pops first, a new byte fills a free slot
   always_comb begin
      rx1_next  = rx1_reg;
      rx2_next  = rx2_reg;
      rx1v_next = rx1v_reg;
      rx2v_next = rx2v_reg;
      ovf_set   = 1'b0;
      if (data_rd && bufm) begin
         rx2_next  = rx1_reg; // R21
         rx2v_next = rx1v_reg;
         rx1v_next = 1'b0;
      end
      if (done && bufm) begin
         if (!rx2v_next) begin
            rx2_next  = rx_byte;
            rx2v_next = 1'b1;
         end else if (!rx1v_next) begin
            rx1_next  = rx_byte;
            rx1v_next = 1'b1;
         end else begin
            ovf_set = 1'b1; // R22
         end
      end
   end

   // Receive storage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx1_reg  <= spihp_pkg::DATA_RST;
         rx2_reg  <= spihp_pkg::DATA_RST;
         rxd_reg  <= spihp_pkg::DATA_RST;
         rx1v_reg <= 1'b0;
         rx2v_reg <= 1'b0;
      end else begin
         rx1_reg  <= rx1_next;
         rx2_reg  <= rx2_next;
         rx1v_reg <= bufm & rx1v_next;
         rx2v_reg <= bufm & rx2v_next;
         if (done && !bufm) begin
            rxd_reg <= rx_byte;
         end
      end
   end

   // Unbuffered flags; set wins over every clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         if_reg     <= 1'b0;
         write_collision_flag_reg  <= 1'b0;
         arm_if_reg <= 1'b0;
         arm_wc_reg <= 1'b0;
      end else begin
         if ((done || sel_trig) && !bufm) begin
            if_reg <= 1'b1; // R15
         end else if (vector_ack || (arm_if_reg && (data_rd || data_wr))) begin
            if_reg <= 1'b0; // R16
         end
         if (data_wr && !bufm && busy_any) begin
            write_collision_flag_reg <= 1'b1; // R18
         end else if (arm_wc_reg && (data_rd || data_wr)) begin
            write_collision_flag_reg <= 1'b0; // R18
         end
         if (flags_rd) begin
            arm_if_reg <= if_reg;
            arm_wc_reg <= write_collision_flag_reg;
         end else if (data_rd || data_wr) begin
            arm_if_reg <= 1'b0;
            arm_wc_reg <= 1'b0;
         end
      end
   end

   // Buffered flags; receive, transfer and select trigger clear on write one, empty on data write, overflow on data read; set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rxc_reg  <= 1'b0;
         txc_reg  <= 1'b0;
         dre_reg  <= 1'b0; // R19
         select_trig_flag_reg <= 1'b0;
         ovf_reg  <= 1'b0;
      end else begin
         if (done && bufm) begin
            rxc_reg <= 1'b1; // R14
         end else if ((flags_wr && wdat[7]) || !(rx1v_next || rx2v_next)) begin
            rxc_reg <= 1'b0; // R14
         end
         if (done && bufm && !txfull_reg) begin
            txc_reg <= 1'b1; // R17
         end else if (flags_wr && wdat[6]) begin
            txc_reg <= 1'b0;
         end
         if (done && bufm && txfull_reg) begin
            dre_reg <= 1'b1; // R19
         end else if (data_wr) begin
            dre_reg <= 1'b0; // R20
         end
         if (sel_trig && bufm) begin
            select_trig_flag_reg <= 1'b1; // R23
         end else if (flags_wr && wdat[4]) begin
            select_trig_flag_reg <= 1'b0;
         end
         if (ovf_set) begin
            ovf_reg <= 1'b1; // R22
         end else if (data_rd) begin
            ovf_reg <= 1'b0;
         end
      end
   end

   // Flag view depends on mode; unbuffered hides buffered flags
   assign flag_view = bufm ?
      {rxc_reg, txc_reg, dre_reg, select_trig_flag_reg, 3'h0, ovf_reg} :
      {if_reg, write_collision_flag_reg, 6'h00}; // R19
   assign irq_src = bufm ?
      |(inten_reg[7:4] & {rxc_reg, txc_reg, dre_reg, select_trig_flag_reg}) : // R12
      (inten_reg[0] & if_reg); // R13

   // Read mux; unmapped addresses read zero
   always_comb begin
      unique case (haddr[7:2])
         spihp_pkg::IDX_CTRL_A: rd_val = ctrl_a_reg;
         spihp_pkg::IDX_CTRL_B: rd_val = ctrl_b_reg;
         spihp_pkg::IDX_INTEN:  rd_val = bufm ? inten_reg :
                                         (inten_reg & 8'h01); // R12
         spihp_pkg::IDX_FLAGS:  rd_val = flag_view;
         spihp_pkg::IDX_DATA:   rd_val = bufm ? rx2_reg : rxd_reg; // R21
         default:               rd_val = 8'h00;
      endcase
   end

   // Bus slave: zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= 6'h00;
         hrdata      <= 32'h0000_0000;
         hreadyout   <= 1'b0;
         hresp       <= 1'b0;
      end else begin
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         wr_pend_reg <= ap & hwrite & (haddr[1:0] == 2'h0);
         wr_idx_reg  <= haddr[7:2];
         if (rd_now) begin
            hrdata <= {24'h00_0000, rd_val};
         end
      end
   end

   // Pin drivers and interrupt line, all registered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sck_oe_n_reg  <= 1'b1;
         mosi_oe_n_reg <= 1'b1;
         miso_oe_n_reg <= 1'b1;
         irq_reg       <= 1'b0;
      end else begin
         sck_oe_n_reg  <= ~(en & host);
         mosi_oe_n_reg <= ~(en & host);
         miso_oe_n_reg <= ~(en & ~host & ~ss_n);
         irq_reg       <= irq_src; // R26
      end
   end
   assign sck_out   = sck_reg;
   assign sck_oe_n  = sck_oe_n_reg;
   assign mosi_out  = out_bit_reg;
   assign mosi_oe_n = mosi_oe_n_reg;
   assign miso_out  = out_bit_reg;
   assign miso_oe_n = miso_oe_n_reg;
   assign irq       = irq_reg;

   // Helper: cycles since the host clock last moved or a transfer started
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_reg <= 7'h00;
      end else if (start || tick) begin
         gap_reg <= 7'h00;
      end else begin
         gap_reg <= gap_reg + 7'h01;
      end
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_disabled;
      !en |=> !busy_reg && edge_cnt_reg == 4'h0;
   endproperty
   a_disabled: // R05
      assert property (p_disabled) else $error("busy while disabled");
   property p_seltrig;
      sel_trig && !ctla_wr |=> !ctrl_a_reg.host_mode;
   endproperty
   a_seltrig: // R02
      assert property (p_seltrig) else $error("host mode kept");
   property p_ssd;
      host && ctrl_b_reg.select_ignore && !ctla_wr |=> host;
   endproperty
   a_ssd: // R09
      assert property (p_ssd) else $error("host mode lost");
   property p_rate;
      busy_reg && tick |-> gap_reg == half - 7'h01;
   endproperty
   a_rate: // R03 R04
      assert property (p_rate) else $error("serial clock rate wrong");
   property p_idle;
      !busy_reg && host && en ##1 !busy_reg && $stable(ctrl_b_reg)
         |-> sck_out == cpol;
   endproperty
   a_idle: // R11
      assert property (p_idle) else $error("idle clock level wrong");
   property p_irq_buf;
      bufm && (inten_reg[7:4] & {rxc_reg, txc_reg, dre_reg, select_trig_flag_reg})
         != 4'h0 |=> irq;
   endproperty
   a_irq_buf: // R12
      assert property (p_irq_buf) else $error("buffered irq missing");
   property p_ovf;
      done && bufm && rx1v_reg && rx2v_reg && !data_rd |=> ovf_reg;
   endproperty
   a_ovf: // R22
      assert property (p_ovf) else $error("overflow not flagged");
   property p_write_collision_flag;
      data_wr && !bufm && busy_any |=> write_collision_flag_reg;
   endproperty
   a_write_collision_flag: // R18
      assert property (p_write_collision_flag) else $error("collision not flagged");
   property p_abort;
      en && !host && ss_n |=> edge_cnt_reg == 4'h0;
   endproperty
   a_abort: // R24
      assert property (p_abort) else $error("byte not abandoned");
   property p_pop;
      data_rd && bufm |=> hrdata[7:0] == $past(rx2_reg);
   endproperty
   a_pop: // R21
      assert property (p_pop) else $error("wrong receive buffer read");
   property p_txbuf;
      data_wr && bufm && !direct && !txfull_reg && !done |=> txfull_reg;
   endproperty
   a_txbuf: // R07
      assert property (p_txbuf) else $error("transmit buffer not loaded");
endmodule

/* verification/spihp_far_model.sv */
module spihp_far_model (
   // Serial lines
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       sel_n,
   output logic            miso,
   // Setup and result
   input  wire logic [1:0] mode,
   input  wire logic [7:0] load,
   output logic [7:0]      rx
);
   timeunit 1ns;
   timeprecision 1ps;
   int k;
   // Quiet start, no byte seen yet
   initial begin
      miso = 1'b0;
      rx = 8'h00;
      k = 0;
   end
   // Select low opens a byte; phase 0 needs its first bit before any edge
   always @(negedge sel_n) begin
      k = 0;
      if (!mode[0]) miso = load[7];
   end
   // Released line shows the inverse so a stale bit can never pass
   always @(posedge sel_n) miso = ~miso;
   // Leading edge flips sck against its idle level; phase picks its role
   always @(sck) begin
      if (!sel_n) begin
         if ((sck ^ mode[1]) ^ mode[0]) rx = {rx[6:0], mosi};
         else begin
            k = k + 1;
            if (k - mode[0] < 8) miso = load[7 - (k - mode[0])];
         end
      end
   end
endmodule

/* verification/test_spi_host_peripheral_ctrl.sv */
module test_spi_host_peripheral_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite, vector_ack, ss_n, sel_n;
   logic        hreadyout, hresp, irq, sck_out, sck_oe_n, p_miso;
   logic        mosi_out, mosi_oe_n, miso_out, miso_oe_n;
   logic [7:0]  haddr, p_load, p_rx;
   logic [1:0]  htrans, p_mode;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, hrdata_s, q;
   wire logic   sck_w, mosi_w, miso_w;
   int          miscompares, comparisons;
   int          hpt[4] = '{2, 8, 32, 64};
   // Undriven mosi shows the inverse of the last value; undriven sck rests at the mode's idle level
   assign sck_w = sck_oe_n ? p_mode[1] : sck_out;
   assign mosi_w = mosi_oe_n ? ~mosi_out : mosi_out;
   assign miso_w = miso_oe_n ? p_miso : miso_out;
   spihp_top spihp_top_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .vector_ack(vector_ack), .irq(irq),
      .sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
      .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
      .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
      .ss_n_in(ss_n));
   spihp_far_model spihp_far_model_i (
      .sck(sck_w), .mosi(mosi_w), .sel_n(sel_n), .miso(p_miso),
      .mode(p_mode), .load(p_load), .rx(p_rx));
   // 200 MHz clock
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // Verdict and end of run
   task automatic stop_test;
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Wait for hready sampled high at a rising edge; data taken there
   task automatic wt;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
         if (n > 100) begin
            miscompares++;
            stop_test();
         end
      end while (hreadyout !== 1'b1);
      hrdata_s = hrdata;
   endtask
   // One single word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wt();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      wt();
      q = hrdata_s;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h000000, e});
   endtask
   // Poll the flag register until every masked bit shows
   task automatic wflag(input logic [7:0] m);
      int n;
      n = 0;
      q = 32'h00000000;
      while ((q[7:0] & m) !== m) begin
         bus(1'b0, 8'h0c, 8'h00);
         n++;
         if (n > 2000) begin
            miscompares++;
            stop_test();
         end
      end
   endtask
   // Second sck half period, counted in clock cycles
   task automatic hp(input int e);
      int c;
      logic s;
      for (int i = 0; i < 2; i++) begin
         s = sck_out;
         c = 0;
         while (sck_out === s && c < 5000) begin
            @(negedge hclk);
            c++;
         end
      end
      @(posedge hclk);
      chk(c, e);
      if (c >= 5000) stop_test();
   endtask
   // Host byte with the far side selected; data register left unread
   task automatic xfer(input logic [7:0] t, input logic [7:0] ld, input int e);
      p_load <= ld;
      sel_n <= 1'b0;
      bus(1'b1, 8'h10, t);
      if (e > 0) hp(e);
      wflag(8'h80);
      sel_n <= 1'b1;
   endtask
   // Main sequence
   initial begin
      {hresetn, hsel, hwrite, vector_ack, htrans, haddr} = '0;
      {ss_n, sel_n, hsize, hwdata, p_mode, p_load, q} = {2'b11, 3'h2, 74'h0};
      miscompares = 0;
      comparisons = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(8'h00, 8'h00);
      rd(8'h04, 8'h00);
      rd(8'h0c, 8'h00);
      rd(8'h20, 8'h00);
      bus(1'b1, 8'h00, 8'h20);
      bus(1'b1, 8'h10, 8'hff);
      repeat (100) @(posedge hclk);
      rd(8'h0c, 8'h00);
      bus(1'b1, 8'h08, 8'hf1);
      rd(8'h08, 8'h01);
      // Every clock mode, idle level first
      for (int m = 0; m < 4; m++) begin
         p_mode <= m[1:0];
         bus(1'b1, 8'h04, {6'h00, m[1:0]});
         bus(1'b1, 8'h00, 8'h23);
         chk(sck_out, m[1]);
         xfer(8'hb1, 8'h36, 0);
         chk(p_rx, 8'hb1);
         rd(8'h10, 8'h36);
      end
      bus(1'b1, 8'h00, 8'h63);
      xfer(8'hb1, 8'h36, 0);
      chk(p_rx, 8'h8d);
      rd(8'h10, 8'h6c);
      // Divider codes with and without doubling
      p_mode <= 2'h0;
      bus(1'b1, 8'h04, 8'h00);
      for (int d = 0; d < 8; d++) begin
         bus(1'b1, 8'h00, {2'b00, 1'b1, d[2], 1'b0, d[1:0], 1'b1});
         xfer(8'h5a, 8'hc3, hpt[d[1:0]] >> d[2]);
         bus(1'b0, 8'h10, 8'h00);
      end
      // Second write while busy is dropped
      bus(1'b1, 8'h00, 8'h23);
      sel_n <= 1'b0;
      bus(1'b1, 8'h10, 8'h11);
      bus(1'b1, 8'h10, 8'h22);
      wflag(8'h80);
      sel_n <= 1'b1;
      rd(8'h0c, 8'hc0);
      rd(8'h10, 8'hc3);
      rd(8'h0c, 8'h00);
      // Interrupt held by the done flag until the vector runs
      xfer(8'h77, 8'hc3, 0);
      repeat (2) @(negedge hclk);
      chk(irq, 1'b1);
      @(posedge hclk);
      vector_ack <= 1'b1;
      @(posedge hclk);
      vector_ack <= 1'b0;
      repeat (3) @(negedge hclk);
      chk(irq, 1'b0);
      @(posedge hclk);
      rd(8'h0c, 8'h00);
      // Select pulled low drops host mode unless ignored
      for (int s = 0; s < 2; s++) begin
         bus(1'b1, 8'h04, {5'h00, s[0], 2'h0});
         bus(1'b1, 8'h00, 8'h21);
         ss_n <= 1'b0;
         repeat (6) @(posedge hclk);
         rd(8'h00, s[0] ? 8'h21 : 8'h01);
         ss_n <= 1'b1;
         rd(8'h0c, s[0] ? 8'h00 : 8'h80);
         rd(8'h10, 8'hc3);
      end
      // Buffered with receive wait: first write goes straight out
      bus(1'b1, 8'h04, 8'hc0);
      rd(8'h08, 8'hf1);
      bus(1'b1, 8'h08, 8'h80);
      bus(1'b1, 8'h00, 8'h23);
      xfer(8'h43, 8'h5a, 0);
      chk(p_rx, 8'h43);
      chk(irq, 1'b1);
      rd(8'h0c, 8'hc0);
      rd(8'h10, 8'h5a);
      bus(1'b1, 8'h0c, 8'h40);
      rd(8'h0c, 8'h00);
      chk(irq, 1'b0);
      // Buffered select trigger drops host mode and sets its flag
      ss_n <= 1'b0;
      repeat (6) @(posedge hclk);
      rd(8'h00, 8'h03);
      ss_n <= 1'b1;
      rd(8'h0c, 8'h10);
      bus(1'b1, 8'h0c, 8'h10);
      rd(8'h0c, 8'h00);
      // No receive wait: a dummy byte goes out before the written one
      bus(1'b1, 8'h04, 8'h80);
      bus(1'b1, 8'h00, 8'h23);
      p_load <= 8'h3c;
      sel_n <= 1'b0;
      bus(1'b1, 8'h10, 8'h44);
      wflag(8'h40);
      sel_n <= 1'b1;
      chk(p_rx, 8'h44);
      rd(8'h0c, 8'he0);
      rd(8'h10, 8'h3c);
      rd(8'h10, 8'h00);
      bus(1'b1, 8'h10, 8'h55);
      rd(8'h0c, 8'h40);
      stop_test();
   end
endmodule
